// ===== hdl/multibyte_field_commit_and_port_pins.sv
// Field bank with atomic commit, instanced blocks and shared port pins
//
// Overview of operation
// - Lowest byte of a field at its base address, higher bytes above.
// - Bit zero is the least significant; top bit is width minus one.
// - Atomic field lower bytes go to a shadow; old value stays in use.
// - Writing the top byte of an atomic field applies all bytes at once.
// - Non-atomic field bytes apply immediately on each write.
// - Block instance i sits at base plus i times the stride.
// - In I2C mode the shared pin enables outputs when source select is 0.
// - In I2C mode pin polarity and pull-up/pull-down follow their fields.
// - In SPI mode the shared pin is an active-low chip select.
// - Clock pin serves I2C or SPI clock; pull-up follows its field.
// - In SPI mode the data pin carries both directions on one wire.
`include "field_commit_params.svh"
module multibyte_field_commit_and_port_pins
	import field_commit_pkg::*;
#(
	parameter int OUT_COUNT = `OUT_COUNT
) (
	// Clocks and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic link_clk,

	// Port mode strap
	input wire port_mode_type port_mode,

	// Byte writes from the serial engine, link clock domain
	input wire logic link_wr_valid,
	input wire wr_byte_type link_wr,

	// Byte readback, system clock domain
	input wire logic [7:0] rd_addr,
	output logic [7:0] rd_data_q,

	// Shared enable or chip-select pin
	input wire logic enable_or_select_pin,

	// Serial clock pin, stretched low by the engine in I2C mode
	input wire logic engine_scl_hold,
	output logic scl_out,
	output logic scl_oe,

	// Serial data pin
	input wire logic engine_sda_drive_low,
	input wire logic engine_sdo,
	input wire logic engine_sdo_en,
	output logic sda_out,
	output logic sda_oe,

	// Pin and pad controls
	output logic outputs_enabled_q,
	output logic chip_selected_q,
	output logic enable_pin_pullup_on_q,
	output logic enable_pin_pulldown_on_q,
	output logic clock_pin_pullup_on_q,
	output logic data_pin_pullup_on_q,
	output logic ref_input_buffer_on_q,
	output logic ref_input_bias_on_q,

	// Field values applied to the functional logic
	output logic [8*`SYS_DIV_BYTES-1:0] sys_div_q,
	output logic [8*`DCO_WORD_BYTES-1:0] dco_word_q,
	output logic [OUT_COUNT-1:0][7:0] out_cnfg_q
);

	////////////////////////////////////////////////////////////////////////
	// Synchronisers

	logic mode_s1_q;
	logic mode_s2_q;
	logic pin_s1_q;
	logic pin_s2_q;
	logic cs_link_s1_q;
	logic cs_link_s2_q;
	logic mode_link_s1_q;
	logic mode_link_s2_q;
	logic is_i2c;

	// Mode is a strap but still arrives from a pin
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mode_s1_q <= 1'b0;
			mode_s2_q <= 1'b0;
		end else begin
			mode_s1_q <= (port_mode == PORT_SPI);
			mode_s2_q <= mode_s1_q;
		end
	end

	assign is_i2c = !mode_s2_q;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1_q <= 1'b1;
			pin_s2_q <= 1'b1;
		end else begin
			pin_s1_q <= enable_or_select_pin;
			pin_s2_q <= pin_s1_q;
		end
	end

	// Select sampled on the serial clock itself; it only matters while
	// that clock runs, i.e. inside a frame
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			cs_link_s1_q <= 1'b1;
			cs_link_s2_q <= 1'b1;
			mode_link_s1_q <= 1'b0;
			mode_link_s2_q <= 1'b0;
		end else begin
			cs_link_s1_q <= enable_or_select_pin;
			cs_link_s2_q <= cs_link_s1_q;
			mode_link_s1_q <= (port_mode == PORT_SPI);
			mode_link_s2_q <= mode_link_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write path

	logic link_wr_ok;
	logic wr_valid;
	wr_byte_type wr;

	// SPI writes only count while the device is selected
	assign link_wr_ok = link_wr_valid &&
		(!mode_link_s2_q || !cs_link_s2_q);

	byte_write_crossing u_crossing (
		.clk_sys(clk_sys),
		.link_clk(link_clk),
		.rst_b(rst_b),
		.link_wr_valid(link_wr_ok),
		.link_wr(link_wr),
		.sys_wr_valid(wr_valid),
		.sys_wr(wr)
	);

	////////////////////////////////////////////////////////////////////////
	// Multi-byte fields

	multibyte_field #(
		.BYTES(`SYS_DIV_BYTES),
		.ATOMIC(1'b0),
		.BASE(`ADDR_SYS_DIV),
		.RST(`RST_SYS_DIV)
	) u_sys_div (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.wr_valid(wr_valid),
		.wr(wr),
		.value_q(sys_div_q)
	);

	// Frequency word must never be seen half-updated
	multibyte_field #(
		.BYTES(`DCO_WORD_BYTES),
		.ATOMIC(1'b1),
		.BASE(`ADDR_DCO_WORD),
		.RST(`RST_DCO_WORD)
	) u_dco_word (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.wr_valid(wr_valid),
		.wr(wr),
		.value_q(dco_word_q)
	);

	////////////////////////////////////////////////////////////////////////
	// Single-byte configuration registers

	logic [7:0] pin_cnfg_q;
	logic [7:0] ref_cnfg_q;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pin_cnfg_q <= `RST_PIN_CNFG;
		end else if (wr_valid && wr.addr == `ADDR_PIN_CNFG) begin
			pin_cnfg_q <= wr.data;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ref_cnfg_q <= `RST_REF_CNFG;
		end else if (wr_valid && wr.addr == `ADDR_REF_CNFG) begin
			ref_cnfg_q <= wr.data;
		end
	end

	// Instanced output blocks
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			out_cnfg_q <= {OUT_COUNT{`RST_OUT_CNFG}};
		end else if (wr_valid) begin
			for (int i = 0; i < OUT_COUNT; i++) begin
				if (wr.addr == inst_base(`ADDR_OUT_BASE, `OUT_STRIDE,
					8'(i))) begin
					out_cnfg_q[i] <= wr.data;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Readback

	function automatic logic [7:0] read_byte(input logic [7:0] addr);
		logic [7:0] data;
		data = `RD_UNMAPPED;
		for (int i = 0; i < `SYS_DIV_BYTES; i++) begin
			if (byte_hit(addr, `ADDR_SYS_DIV, 8'(i))) begin
				data = sys_div_q[8*i +: 8];
			end
		end
		// Applied value, not the shadow, is what reads return
		for (int i = 0; i < `DCO_WORD_BYTES; i++) begin
			if (byte_hit(addr, `ADDR_DCO_WORD, 8'(i))) begin
				data = dco_word_q[8*i +: 8];
			end
		end
		for (int i = 0; i < OUT_COUNT; i++) begin
			if (addr == inst_base(`ADDR_OUT_BASE, `OUT_STRIDE, 8'(i))) begin
				data = out_cnfg_q[i];
			end
		end
		if (addr == `ADDR_PIN_CNFG) begin
			data = pin_cnfg_q;
		end else if (addr == `ADDR_REF_CNFG) begin
			data = ref_cnfg_q;
		end
		read_byte = data;
	endfunction

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rd_data_q <= `RD_UNMAPPED;
		end else begin
			rd_data_q <= read_byte(rd_addr);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared enable or select pin

	logic pin_active;

	assign pin_active = (pin_s2_q == pin_cnfg_q[`PIN_OE_POL_BIT]);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			outputs_enabled_q <= 1'b0;
			chip_selected_q <= 1'b0;
		end else begin
			// Other enable sources are handled elsewhere; pass here
			if (is_i2c && !pin_cnfg_q[`PIN_OE_SEL_BIT]) begin
				outputs_enabled_q <= pin_active;
			end else begin
				outputs_enabled_q <= 1'b1;
			end
			chip_selected_q <= !is_i2c && !pin_s2_q;
		end
	end

	// In SPI mode the select idles high, so keep it pulled up
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			enable_pin_pullup_on_q <= 1'b0;
			enable_pin_pulldown_on_q <= 1'b0;
		end else if (is_i2c) begin
			enable_pin_pullup_on_q <= pin_cnfg_q[`PIN_ENABLE_PIN_PULLUP_ON_BIT];
			enable_pin_pulldown_on_q <= pin_cnfg_q[`PIN_ENABLE_PIN_PULLDOWN_ON_BIT];
		end else begin
			enable_pin_pullup_on_q <= 1'b1;
			enable_pin_pulldown_on_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial clock and data pins

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			clock_pin_pullup_on_q <= 1'b0;
			data_pin_pullup_on_q <= 1'b0;
		end else begin
			clock_pin_pullup_on_q <= pin_cnfg_q[`PIN_CLOCK_PIN_PULLUP_ON_BIT];
			data_pin_pullup_on_q <= pin_cnfg_q[`PIN_DATA_PIN_PULLUP_ON_BIT];
		end
	end

	// Clock pin is open-drain in I2C, input only for SPI
	assign scl_out = 1'b0;
	assign scl_oe = is_i2c && engine_scl_hold;

	// Open-drain data for I2C, one shared wire both ways for SPI
	always_comb begin
		if (is_i2c) begin
			sda_out = 1'b0;
			sda_oe = engine_sda_drive_low;
		end else begin
			sda_out = engine_sdo;
			sda_oe = engine_sdo_en && !pin_s2_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reference input pad controls

	// Pad follows software; bias for AC coupling, buffer off when unused
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ref_input_buffer_on_q <= 1'b0;
			ref_input_bias_on_q <= 1'b0;
		end else begin
			ref_input_buffer_on_q <= ref_cnfg_q[`REF_BUF_EN_BIT];
			ref_input_bias_on_q <= ref_cnfg_q[`REF_BIAS_EN_BIT];
		end
	end

endmodule

// ===== hdl/field_commit_params.svh
// Register offsets, reset values, bit positions and sizes for the field bank
`ifndef FIELD_COMMIT_PARAMS_SVH
`define FIELD_COMMIT_PARAMS_SVH

// Non-atomic 16-bit system divider field
`define ADDR_SYS_DIV 8'h10
`define SYS_DIV_BYTES 2
`define RST_SYS_DIV 16'h0000

// Atomic 32-bit frequency word
`define ADDR_DCO_WORD 8'h20
`define DCO_WORD_BYTES 4
`define RST_DCO_WORD 32'h0000_0000

// Pin configuration byte
`define ADDR_PIN_CNFG 8'h30
`define RST_PIN_CNFG 8'h36
`define PIN_OE_SEL_BIT 0
`define PIN_OE_POL_BIT 1
`define PIN_ENABLE_PIN_PULLUP_ON_BIT 2
`define PIN_ENABLE_PIN_PULLDOWN_ON_BIT 3
`define PIN_CLOCK_PIN_PULLUP_ON_BIT 4
`define PIN_DATA_PIN_PULLUP_ON_BIT 5

// Reference input configuration byte
`define ADDR_REF_CNFG 8'h31
`define RST_REF_CNFG 8'h01
`define REF_BUF_EN_BIT 0
`define REF_BIAS_EN_BIT 1

// Repeated output block: base plus instance times stride
`define ADDR_OUT_BASE 8'h40
`define OUT_STRIDE 8'h08
`define OUT_COUNT 4
`define RST_OUT_CNFG 8'h00

// Value returned for an unmapped read address
`define RD_UNMAPPED 8'h00

`endif

// ===== hdl/field_commit_pkg.sv
// Types and shared decode helpers for the field bank
package field_commit_pkg;

	typedef enum logic {
		PORT_I2C,
		PORT_SPI
	} port_mode_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} wr_byte_type;

	// True when addr selects byte idx of a field starting at base
	function automatic logic byte_hit(input logic [7:0] addr,
		input logic [7:0] base, input logic [7:0] idx);
		byte_hit = (addr == 8'(base + idx));
	endfunction

	// Base address of instance inst of a repeated block
	function automatic logic [7:0] inst_base(input logic [7:0] base,
		input logic [7:0] stride, input logic [7:0] inst);
		inst_base = 8'(base + 8'(inst * stride));
	endfunction

endpackage

// ===== hdl/byte_write_crossing.sv
// Moves byte writes from the serial-clock domain into the system domain
module byte_write_crossing import field_commit_pkg::*; (
	// Clocks and reset
	input wire logic clk_sys,
	input wire logic link_clk,
	input wire logic rst_b,
	// Link side
	input wire logic link_wr_valid,
	input wire wr_byte_type link_wr,
	// System side
	output logic sys_wr_valid,
	output wr_byte_type sys_wr
);

	logic toggle_q;
	wr_byte_type hold_q;
	logic sync1_q;
	logic sync2_q;
	logic seen_q;

	// Held word stays put until the next write, many link clocks later
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			hold_q <= '0;
			toggle_q <= 1'b0;
		end else if (link_wr_valid) begin
			hold_q <= link_wr;
			toggle_q <= ~toggle_q;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			seen_q <= 1'b0;
		end else begin
			sync1_q <= toggle_q;
			sync2_q <= sync1_q;
			seen_q <= sync2_q;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sys_wr_valid <= 1'b0;
			sys_wr <= '0;
		end else begin
			sys_wr_valid <= sync2_q ^ seen_q;
			if (sync2_q ^ seen_q) begin
				sys_wr <= hold_q;
			end
		end
	end

endmodule

// ===== hdl/multibyte_field.sv
// One little-endian multi-byte field, atomic or applied byte by byte
module multibyte_field import field_commit_pkg::*; #(
	parameter int BYTES = 2,
	parameter bit ATOMIC = 1'b0,
	parameter logic [7:0] BASE = 8'h00,
	parameter logic [8*BYTES-1:0] RST = '0
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Byte write
	input wire logic wr_valid,
	input wire wr_byte_type wr,
	// Value seen by the functional logic
	output logic [8*BYTES-1:0] value_q
);

	logic [8*BYTES-1:0] shadow_q;
	logic [8*BYTES-1:0] commit_d;

	// Buffered lower bytes plus the top byte being written
	always_comb begin
		commit_d = shadow_q;
		commit_d[8*(BYTES-1) +: 8] = wr.data;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			shadow_q <= RST;
		end else if (wr_valid && ATOMIC) begin
			for (int i = 0; i < BYTES - 1; i++) begin
				if (byte_hit(wr.addr, BASE, 8'(i))) begin
					shadow_q[8*i +: 8] <= wr.data;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			value_q <= RST;
		end else if (wr_valid) begin
			for (int i = 0; i < BYTES; i++) begin
				if (byte_hit(wr.addr, BASE, 8'(i))) begin
					if (!ATOMIC) begin
						value_q[8*i +: 8] <= wr.data;
					end else if (i == BYTES - 1) begin
						value_q <= commit_d;
					end
				end
			end
		end
	end

endmodule

// ===== testbench/field_bank_sva.sv
// Checker for the field bank ports, bound to the top module
`include "field_commit_params.svh"
module field_bank_checker import field_commit_pkg::*; (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Mode, read and pins
	input wire port_mode_type port_mode,
	input wire logic [7:0] rd_addr,
	input wire logic [7:0] rd_data_q,
	input wire logic enable_or_select_pin,
	input wire logic engine_scl_hold,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic engine_sda_drive_low,
	input wire logic engine_sdo,
	input wire logic engine_sdo_en,
	input wire logic sda_out,
	input wire logic sda_oe,
	// Results
	input wire logic chip_selected_q,
	input wire logic enable_pin_pullup_on_q,
	input wire logic enable_pin_pulldown_on_q,
	input wire logic [15:0] sys_div_q,
	input wire logic [31:0] dco_word_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	// Mode flops need settling before the pins reflect a strap
	sequence s_spi_held;
		(port_mode == PORT_SPI) [*5];
	endsequence
	sequence s_i2c_held;
		(port_mode == PORT_I2C) [*5];
	endsequence
	sequence s_rd_sys;
		rd_addr == `ADDR_SYS_DIV ##1 $stable(sys_div_q);
	endsequence
	sequence s_rd_dco;
		rd_addr == 8'h23 ##1 $stable(dco_word_q);
	endsequence

	property p_rd_sys;
		s_rd_sys |-> rd_data_q == sys_div_q[7:0];
	endproperty
	property p_rd_dco;
		s_rd_dco |-> rd_data_q == dco_word_q[31:24];
	endproperty
	property p_unmapped;
		rd_addr == 8'h01 |=> rd_data_q == `RD_UNMAPPED;
	endproperty
	property p_sys_byte;
		$changed(sys_div_q) |->
			$stable(sys_div_q[15:8]) || $stable(sys_div_q[7:0]);
	endproperty
	property p_dco_step;
		$changed(dco_word_q) |=> $stable(dco_word_q) [*3];
	endproperty
	property p_scl;
		scl_oe |-> engine_scl_hold && !scl_out;
	endproperty
	property p_sda_oe;
		sda_oe |-> engine_sdo_en || engine_sda_drive_low;
	endproperty
	property p_sda_out;
		sda_oe && !engine_sda_drive_low |-> sda_out == engine_sdo;
	endproperty
	property p_cs;
		chip_selected_q |-> !$past(enable_or_select_pin, 3);
	endproperty
	property p_i2c_cs;
		s_i2c_held |-> !chip_selected_q;
	endproperty
	property p_spi_pull;
		s_spi_held |-> enable_pin_pullup_on_q && !enable_pin_pulldown_on_q;
	endproperty

	a_rd_sys: assert property (p_rd_sys) else $error("sys read");
	a_rd_dco: assert property (p_rd_dco) else $error("dco read");
	a_unmapped: assert property (p_unmapped) else $error("unmapped");
	a_sys_byte: assert property (p_sys_byte) else $error("sys byte");
	a_dco_step: assert property (p_dco_step) else $error("dco step");
	a_scl: assert property (p_scl) else $error("scl drive");
	a_sda_oe: assert property (p_sda_oe) else $error("sda enable");
	a_sda_out: assert property (p_sda_out) else $error("sda data");
	a_cs: assert property (p_cs) else $error("chip select");
	a_i2c_cs: assert property (p_i2c_cs) else $error("i2c select");
	a_spi_pull: assert property (p_spi_pull) else $error("spi pulls");
endmodule

bind multibyte_field_commit_and_port_pins field_bank_checker
	field_bank_checker_i (.clk_sys, .rst_b, .port_mode, .rd_addr,
	.rd_data_q, .enable_or_select_pin, .engine_scl_hold, .scl_out,
	.scl_oe, .engine_sda_drive_low, .engine_sdo, .engine_sdo_en, .sda_out,
	.sda_oe, .chip_selected_q, .enable_pin_pullup_on_q,
	.enable_pin_pulldown_on_q, .sys_div_q, .dco_word_q);

// ===== testbench/host_model.sv
// Serial host model: gated link clock, byte writes, shared select pin
module host_model import field_commit_pkg::*; (
	// Link side toward the block
	output logic link_clk,
	output logic link_wr_valid,
	output wr_byte_type link_wr,
	output logic enable_or_select_pin
);
	timeunit 1ns;
	timeprecision 10ps;

	initial begin
		link_clk = 1'b0;
		link_wr_valid = 1'b0;
		link_wr = '0;
		enable_or_select_pin = 1'b1;
	end

	// Clock runs only inside a frame
	task automatic tick(input int n);
		repeat (n) begin
			#3.75 link_clk = 1'b1;
			#7.5 link_clk = 1'b0;
			#3.75;
		end
	endtask

	// Select level between frames, changed on a system clock edge
	task automatic set_select(input logic v);
		enable_or_select_pin <= v;
	endtask

	// Select leads the byte so the link synchroniser sees it
	task automatic wr_byte(input logic [7:0] a, input logic [7:0] d,
		input logic cs);
		enable_or_select_pin = cs;
		tick(3);
		link_wr = '{addr: a, data: d};
		link_wr_valid = 1'b1;
		tick(1);
		link_wr_valid = 1'b0;
		link_wr = ~link_wr;
		tick(3);
		enable_or_select_pin = 1'b1;
	endtask
endmodule

// ===== testbench/tb.sv
// Self-checking bench: byte writes, atomic commit, pins and modes
`include "field_commit_params.svh"
module tb import field_commit_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	port_mode_type port_mode = PORT_I2C;
	logic [7:0] rd_addr = 8'h00;
	logic engine_scl_hold = 1'b0;
	logic engine_sda_drive_low = 1'b0;
	logic engine_sdo = 1'b0;
	logic engine_sdo_en = 1'b0;
	logic link_clk, link_wr_valid, enable_or_select_pin;
	wr_byte_type link_wr;
	logic [7:0] rd_data_q;
	logic scl_out, scl_oe, sda_out, sda_oe;
	logic outputs_enabled_q, chip_selected_q, enable_pin_pullup_on_q;
	logic enable_pin_pulldown_on_q, clock_pin_pullup_on_q;
	logic data_pin_pullup_on_q, ref_input_buffer_on_q, ref_input_bias_on_q;
	logic [15:0] sys_div_q;
	logic [31:0] dco_word_q;
	logic [3:0][7:0] out_cnfg_q;
	logic [7:0] pads;
	int bad_count = 0;
	int compares = 0;

	assign pads = {outputs_enabled_q, chip_selected_q, enable_pin_pullup_on_q,
		enable_pin_pulldown_on_q, clock_pin_pullup_on_q, data_pin_pullup_on_q,
		ref_input_buffer_on_q, ref_input_bias_on_q};

	always #2 clk_sys = ~clk_sys;

	multibyte_field_commit_and_port_pins #(.OUT_COUNT(4))
		multibyte_field_commit_and_port_pins_i (.clk_sys, .rst_b, .link_clk,
		.port_mode, .link_wr_valid, .link_wr, .rd_addr, .rd_data_q,
		.enable_or_select_pin, .engine_scl_hold, .scl_out, .scl_oe,
		.engine_sda_drive_low, .engine_sdo, .engine_sdo_en, .sda_out, .sda_oe,
		.outputs_enabled_q, .chip_selected_q, .enable_pin_pullup_on_q,
		.enable_pin_pulldown_on_q, .clock_pin_pullup_on_q,
		.data_pin_pullup_on_q, .ref_input_buffer_on_q, .ref_input_bias_on_q,
		.sys_div_q, .dco_word_q, .out_cnfg_q);

	host_model host_model_i (.link_clk, .link_wr_valid, .link_wr,
		.enable_or_select_pin);

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		rd_addr <= a;
		repeat (2) @(posedge clk_sys);
		#1 chk(rd_data_q, exp);
	endtask

	// Realign to the system clock so checks never meet an edge
	task automatic wr_cs(input logic [7:0] a, input logic [7:0] d,
		input logic cs);
		host_model_i.wr_byte(a, d, cs);
		@(posedge clk_sys);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wr_cs(a, d, 1'b1);
	endtask

	// Pin passes two flops and a register
	task automatic pin_to(input logic v);
		@(posedge clk_sys);
		host_model_i.set_select(v);
		repeat (5) @(posedge clk_sys);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk(pads, 8'hAE);
		rd(`ADDR_PIN_CNFG, `RST_PIN_CNFG);
		rd(`ADDR_REF_CNFG, `RST_REF_CNFG);
		rd(8'h01, `RD_UNMAPPED);
		$display("reset test done");
	endtask

	task automatic t_plain;
		wr(8'h10, 8'hAB);
		chk(sys_div_q, 32'h00AB);
		wr(8'h11, 8'hCD);
		chk(sys_div_q, 32'hCDAB);
		rd(8'h10, 8'hAB);
		rd(8'h11, 8'hCD);
		$display("plain field test done");
	endtask

	task automatic t_atomic;
		for (int i = 0; i < 3; i++) begin
			wr(8'h20 + 8'(i), 8'(17 * (i + 1)));
			chk(dco_word_q, 32'h0);
		end
		wr(8'h23, 8'h44);
		chk(dco_word_q, 32'h4433_2211);
		wr(8'h20, 8'h99);
		chk(dco_word_q, 32'h4433_2211);
		wr(8'h23, 8'h55);
		chk(dco_word_q, 32'h5533_2299);
		rd(8'h23, 8'h55);
		$display("atomic field test done");
	endtask

	task automatic t_inst;
		for (int i = 0; i < 4; i++) begin
			wr(8'(`ADDR_OUT_BASE + i * `OUT_STRIDE), 8'hA0 + 8'(i));
			chk(out_cnfg_q[i], 8'hA0 + 8'(i));
		end
		rd(8'h48, 8'hA1);
		rd(8'h41, 8'h00);
		$display("instance test done");
	endtask

	task automatic t_pins;
		wr(8'h30, 8'h22);
		pin_to(1'b1);
		chk(pads, 8'h86);
		pin_to(1'b0);
		chk(pads, 8'h06);
		wr(8'h30, 8'h08);
		pin_to(1'b0);
		chk(pads, 8'h92);
		wr(8'h30, 8'h31);
		pin_to(1'b0);
		chk(pads, 8'h8E);
		engine_scl_hold <= 1'b1;
		engine_sda_drive_low <= 1'b1;
		pin_to(1'b1);
		chk({scl_out, scl_oe, sda_out, sda_oe}, 4'b0101);
		engine_scl_hold <= 1'b0;
		engine_sda_drive_low <= 1'b0;
		$display("pin test done");
	endtask

	task automatic t_ref;
		wr(8'h31, 8'h02);
		chk(pads, 8'h8D);
		rd(8'h31, 8'h02);
		$display("reference input test done");
	endtask

	task automatic t_spi;
		@(posedge clk_sys);
		port_mode <= PORT_SPI;
		engine_scl_hold <= 1'b1;
		engine_sdo_en <= 1'b1;
		engine_sdo <= 1'b1;
		pin_to(1'b1);
		chk(pads, 8'hAD);
		wr_cs(8'h10, 8'h5A, 1'b0);
		chk(sys_div_q, 32'hCD5A);
		wr_cs(8'h10, 8'h77, 1'b1);
		chk(sys_div_q, 32'hCD5A);
		pin_to(1'b0);
		chk(pads, 8'hED);
		chk({scl_oe, sda_oe, sda_out}, 3'b011);
		pin_to(1'b1);
		chk({scl_oe, sda_oe, sda_out}, 3'b001);
		$display("spi mode test done");
	endtask

	task automatic print_verdict;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (6) @(posedge clk_sys);
		#1;
		t_reset();
		t_plain();
		t_atomic();
		t_inst();
		t_pins();
		t_ref();
		t_spi();
		print_verdict();
	end

	// About 18 writes of about 110 ns each, with wide margin
	initial begin
		#50000;
		bad_count++;
		print_verdict();
	end
endmodule
